//--- include/flash_cmd_map.svh
// command codes, field positions and timing counts for the buffer program command state machine
// assumes inclusion by the package and both ends; definitions only
// What this block does
// RULE1: host repeats setup until ready reads one
// RULE2: count value is number of words minus one
// RULE3: device latches only low five count bits
// RULE4: writes after count are data, not commands
// RULE5: host sends all words, then confirm next
// RULE6: host aborts by writing another block address
// RULE7: block change during data load gives error
// RULE8: confirm starts program; other commands give error
// RULE9: device decodes the listed command bytes
// RULE10: erase setup accepts only confirm, else error
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
`define CMD_READ_ARRAY   8'hff
`define CMD_PROG_SETUP_A 8'h10
`define CMD_PROG_SETUP_B 8'h40
`define CMD_BUF_SETUP    8'he8
`define CMD_ERASE_SETUP  8'h20
`define CMD_CONFIRM      8'hd0
`define CMD_SUSPEND      8'hb0
`define CMD_READ_STATUS  8'h70
`define COUNT_MSB        4
`define BLOCK_LSB        16
`define BLOCK_MSB        23
`define ADDR_MSB         23
`define STAT_READY_BIT   7
`define STAT_SEQERR_BIT  4
`define PROG_TIME_NS     2000
`define ERASE_TIME_NS    8000
`define CLK_PERIOD_NS    40
`define PROG_CYCLES      ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES     ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_CNT_W       9
`define WAIT_CNT_W       4
`endif

//--- include/flash_cmd_pkg.sv
// types shared by both ends of the flash command link
// assumes flash_cmd_map.svh on the include path
`include "flash_cmd_map.svh"
package flash_cmd_pkg;
  typedef enum logic [13:0] {
    st_read_array = 14'h0001,
    st_read_status= 14'h0002,
    st_prog_setup = 14'h0004,
    st_buf_setup  = 14'h0008,
    st_count_load = 14'h0010,
    st_data_load  = 14'h0020,
    st_buf_confirm= 14'h0040,
    st_prog_busy  = 14'h0080,
    st_erase_setup= 14'h0100,
    st_erase_busy = 14'h0200,
    st_botch      = 14'h0400,
    st_suspended  = 14'h0800,
    st_botch_susp = 14'h1000,
    st_prog_done  = 14'h2000
  } dev_state_type;
  typedef enum logic [7:0] {
    h_idle    = 8'h01,
    h_setup   = 8'h02,
    h_poll    = 8'h04,
    h_count   = 8'h08,
    h_data    = 8'h10,
    h_confirm = 8'h20,
    h_wait    = 8'h40,
    h_done    = 8'h80
  } host_state_type;
endpackage

//--- include/flash_link_if.sv
// bus write/read cycles between host controller and flash command front end
// assumes one shared clock
`timescale 1ns/1ns
interface flash_link_if;
  logic        wr_stb;
  logic        rd_stb;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  modport device (input wr_stb, input rd_stb, input addr, input wdata,
                  output rdata, output rvalid);
  modport host (output wr_stb, output rd_stb, output addr, output wdata,
                input rdata, input rvalid);
endinterface

//--- rtl/flash_buffer_host.sv
// host end: issues one buffered program sequence per request
// assumes the device answers each read one cycle after rd_stb
`timescale 1ns/1ns
`include "flash_cmd_map.svh"
module flash_buffer_host
  import flash_cmd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  flash_link_if.host       link,
  input  wire logic        start_i,
  input  wire logic        abort_i,
  input  wire logic [23:0] base_addr_i,
  input  wire logic [4:0]  count_m1_i,
  input  wire logic [15:0] data_i,
  output logic             data_take_o,
  output logic             done_o,
  output logic             busy_o,
  output logic [7:0]       status_o
);
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  host_state_type state_q;
  logic [4:0]     left_q;
  logic [23:0]    addr_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q     <= h_idle;
      left_q      <= 5'h00;
      addr_q      <= 24'h000000;
      link.wr_stb <= 1'b0;
      link.rd_stb <= 1'b0;
      link.addr   <= 24'h000000;
      link.wdata  <= 16'h0000;
      data_take_o <= 1'b0;
      done_o      <= 1'b0;
      busy_o      <= 1'b0;
      status_o    <= 8'h00;
    end else begin
      link.wr_stb <= 1'b0;
      link.rd_stb <= 1'b0;
      data_take_o <= 1'b0;
      done_o      <= 1'b0;
      case (state_q)
        h_idle: if (start_i) begin
          addr_q  <= base_addr_i;
          left_q  <= count_m1_i;
          busy_o  <= 1'b1;
          state_q <= h_setup;
        end
        h_setup: begin
          link.wr_stb <= 1'b1;
          link.addr   <= addr_q;
          link.wdata  <= {8'h00, `CMD_BUF_SETUP}; // RULE1
          state_q     <= h_poll;
        end
        h_poll: if (link.rvalid) begin
          state_q <= link.rdata[`STAT_READY_BIT] ? h_count : h_setup; // RULE1
        end else if (!link.rd_stb) begin
          link.rd_stb <= 1'b1;
        end
        h_count: begin
          link.wr_stb <= 1'b1;
          link.wdata  <= {11'h000, left_q}; // RULE2
          state_q     <= h_data;
        end
        h_data: begin
          link.wr_stb <= 1'b1;
          link.wdata  <= data_i;
          data_take_o <= 1'b1;
          // a foreign block address ends the sequence early
          link.addr   <= abort_i ? (addr_q ^ (24'h000001 << `BLOCK_LSB)) : addr_q; // RULE6
          if (abort_i) begin
            state_q <= h_wait;
          end else if (left_q == 5'h00) begin
            state_q <= h_confirm; // RULE5
          end else begin
            left_q <= left_q - 5'h01;
          end
        end
        h_confirm: begin
          link.wr_stb <= 1'b1;
          link.addr   <= addr_q;
          link.wdata  <= {8'h00, `CMD_CONFIRM}; // RULE5
          state_q     <= h_wait;
        end
        h_wait: if (link.rvalid && link.rdata[`STAT_READY_BIT]) begin
          status_o <= link.rdata[7:0];
          state_q  <= h_done;
        end else if (!link.rd_stb && !link.rvalid) begin
          link.rd_stb <= 1'b1;
        end
        h_done: begin
          done_o  <= 1'b1;
          busy_o  <= 1'b0;
          state_q <= h_idle;
        end
        default: state_q <= h_idle;
      endcase
    end
  end
endmodule // flash_buffer_host

//--- rtl/flash_command_front_end.sv
// device end: command front end of the flash, buffer program and erase sequences
// assumes link strobes come from logic on clk_i (no synchroniser needed)
`timescale 1ns/1ns
`include "flash_cmd_map.svh"
module flash_command_front_end
  import flash_cmd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  flash_link_if.device     link,
  input  wire logic [15:0] array_data_i,
  output logic             prog_start_o,
  output logic             erase_start_o,
  output logic [4:0]       word_count_o,
  output logic             buf_we_o,
  output logic [4:0]       buf_idx_o,
  output logic [15:0]      buf_data_o,
  output logic [7:0]       state_code_o
);
  // ---------------------------------------------------------------
  // state and datapath
  // ---------------------------------------------------------------
  dev_state_type             state_q;
  dev_state_type             state_d;
  logic [4:0]                left_q;
  logic [`BLOCK_MSB:`BLOCK_LSB] blk_q;
  logic [`BUSY_CNT_W-1:0]    busy_q;
  logic                      seqerr_q;
  logic                      susp_q;
  logic [7:0]                cmd;
  logic                      blk_diff;

  function automatic logic is_cmd(input logic [7:0] c);
    is_cmd = (c == `CMD_READ_ARRAY) || (c == `CMD_PROG_SETUP_A) ||
             (c == `CMD_PROG_SETUP_B) || (c == `CMD_BUF_SETUP) ||
             (c == `CMD_ERASE_SETUP) || (c == `CMD_CONFIRM) ||
             (c == `CMD_SUSPEND) || (c == `CMD_READ_STATUS); // RULE9
  endfunction

  assign cmd      = link.wdata[7:0];
  assign blk_diff = link.addr[`BLOCK_MSB:`BLOCK_LSB] != blk_q;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_buf_setup:   state_d = st_count_load; // ready at once: next write is the count
      st_count_load:  if (link.wr_stb) begin
        state_d = st_data_load; // RULE2 RULE4
      end
      st_data_load:   if (link.wr_stb) begin
        if (blk_diff) begin
          state_d = susp_q ? st_botch_susp : st_botch; // RULE7
        end else if (left_q == 5'h00) begin
          state_d = st_buf_confirm;
        end
      end
      st_buf_confirm: if (link.wr_stb) begin
        if (cmd == `CMD_CONFIRM) begin
          state_d = st_prog_busy; // RULE8
        end else begin
          state_d = susp_q ? st_botch_susp : st_botch; // RULE8
        end
      end
      st_erase_setup: if (link.wr_stb) begin
        state_d = (cmd == `CMD_CONFIRM) ? st_erase_busy : st_botch; // RULE10
      end
      st_prog_busy:   if (busy_q == '0) begin
        state_d = susp_q ? st_suspended : st_prog_done;
      end
      st_erase_busy:  if (link.wr_stb && cmd == `CMD_SUSPEND) begin
        state_d = st_suspended;
      end else if (busy_q == '0) begin
        state_d = st_read_status;
      end
      st_suspended, st_botch_susp: if (link.wr_stb) begin
        case (cmd)
          `CMD_BUF_SETUP: state_d = st_buf_setup;
          `CMD_CONFIRM:   state_d = st_erase_busy;
          default:        state_d = st_suspended;
        endcase
      end
      default: if (link.wr_stb) begin
        case (cmd)
          `CMD_READ_ARRAY:   state_d = st_read_array;
          `CMD_PROG_SETUP_A,
          `CMD_PROG_SETUP_B: state_d = st_prog_setup;
          `CMD_BUF_SETUP:    state_d = st_buf_setup;
          `CMD_ERASE_SETUP:  state_d = st_erase_setup;
          `CMD_READ_STATUS:  state_d = st_read_status;
          default:           state_d = is_cmd(cmd) ? st_read_status : st_read_array;
        endcase
        if (state_q == st_prog_setup) begin
          state_d = st_prog_busy;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= st_read_array;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // suspend flag, word count, block capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      susp_q <= 1'b0;
    end else if (state_d == st_suspended) begin
      susp_q <= 1'b1;
    end else if (state_d == st_erase_busy || state_d == st_botch) begin
      susp_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_q <= 5'h00;
      blk_q  <= '0;
    end else if (state_q == st_count_load && link.wr_stb) begin
      left_q <= link.wdata[`COUNT_MSB:0]; // RULE3
      blk_q  <= link.addr[`BLOCK_MSB:`BLOCK_LSB];
    end else if (state_q == st_data_load && link.wr_stb && !blk_diff && left_q != 5'h00) begin
      left_q <= left_q - 5'h01;
    end
  end

  // error flag: set wins, cleared only by a buffer or erase setup command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seqerr_q <= 1'b0;
    end else if (state_d == st_botch || state_d == st_botch_susp) begin
      seqerr_q <= 1'b1;
    end else if (state_d == st_buf_setup || state_d == st_erase_setup) begin
      seqerr_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // internal operation timer, shortened model of array timing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= '0;
    end else if (state_q != st_prog_busy && state_d == st_prog_busy) begin
      busy_q <= `BUSY_CNT_W'(`PROG_CYCLES);
    end else if (state_q != st_erase_busy && state_d == st_erase_busy) begin
      busy_q <= `BUSY_CNT_W'(`ERASE_CYCLES);
    end else if (busy_q != '0 && (state_q == st_prog_busy || state_q == st_erase_busy)) begin
      busy_q <= busy_q - `BUSY_CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_start_o  <= 1'b0;
      erase_start_o <= 1'b0;
      buf_we_o      <= 1'b0;
      buf_idx_o     <= 5'h00;
      buf_data_o    <= 16'h0000;
      word_count_o  <= 5'h00;
      state_code_o  <= 8'h00;
    end else begin
      prog_start_o  <= state_q == st_buf_confirm && state_d == st_prog_busy; // RULE8
      erase_start_o <= state_q == st_erase_setup && state_d == st_erase_busy; // RULE10
      buf_we_o      <= state_q == st_data_load && link.wr_stb && !blk_diff; // RULE4
      buf_idx_o     <= left_q;
      buf_data_o    <= link.wdata;
      if (state_q == st_count_load && link.wr_stb) begin
        word_count_o <= link.wdata[`COUNT_MSB:0]; // RULE3
      end
      state_code_o  <= {1'b0, state_q[13:7] != 7'h00, state_q[6:1] != 6'h00, seqerr_q,
                        susp_q, state_q == st_read_array, 2'b00};
    end
  end

  // status answers with ready low only while an operation runs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.rdata  <= 16'h0000;
      link.rvalid <= 1'b0;
    end else begin
      link.rvalid <= link.rd_stb;
      // answer only on a read, so the word stands until the next one
      if (!link.rd_stb) begin
        link.rdata <= link.rdata;
      end else if (state_q == st_read_array) begin
        link.rdata <= array_data_i;
      end else begin
        link.rdata <= {8'h00, !(state_q == st_prog_busy || state_q == st_erase_busy),
                       1'b0, susp_q, seqerr_q, 4'h0}; // RULE10
      end
    end
  end
endmodule // flash_command_front_end

//--- test/flash_link_sva.sv
// assertions on the link between the host end and the flash front end
// assumes one clock, active low async reset, signals of flash_link_if
`timescale 1ns/1ns
`include "flash_cmd_map.svh"
module flash_link_sva (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid
);
  // ---
  // sequence tracker: 0 idle, 1 poll, 2 count, 3 data, 4 confirm
  // ---
  logic [2:0] ph_q;
  logic [4:0] rem_q;
  logic [7:0] blk_q;
  logic       conf_q;
  logic       err_q;
  logic       moved;
  assign moved = addr[`BLOCK_MSB:`BLOCK_LSB] != blk_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_q <= 3'h0;
      rem_q <= 5'h00;
      blk_q <= 8'h00;
    end else if (wr_stb) begin
      if (ph_q < 3'h2 && wdata[7:0] == `CMD_BUF_SETUP) begin
        ph_q <= 3'h1;
        blk_q <= addr[`BLOCK_MSB:`BLOCK_LSB];
      end else if (ph_q == 3'h2) begin
        ph_q <= 3'h3;
        rem_q <= wdata[`COUNT_MSB:0];
      end else if (ph_q == 3'h3 && !moved) begin
        rem_q <= rem_q - 5'h01;
        ph_q <= (rem_q == 5'h00) ? 3'h4 : 3'h3;
      end else begin
        ph_q <= 3'h0;
      end
    end else if (ph_q == 3'h1 && rvalid && rdata[`STAT_READY_BIT]) begin
      ph_q <= 3'h2;
    end
  end
  // rvalid wins over a write: a flag is judged by the first answer only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conf_q <= 1'b0;
      err_q <= 1'b0;
    end else if (rvalid) begin
      conf_q <= 1'b0;
      err_q <= 1'b0;
    end else if (wr_stb) begin
      conf_q <= ph_q == 3'h4 && wdata[7:0] == `CMD_CONFIRM;
      err_q <= ph_q == 3'h3 && moved;
    end
  end
  // ---
  // properties
  // ---
  sequence s_setup_wr; wr_stb && wdata[7:0] == `CMD_BUF_SETUP; endsequence
  sequence s_conf_wr; wr_stb && ph_q == 3'h4 && wdata[7:0] == `CMD_CONFIRM; endsequence
  sequence s_ready_rd; rvalid && rdata[`STAT_READY_BIT]; endsequence
  property p_rd_answer; rd_stb |=> rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_cause; rvalid |-> $past(rd_stb); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
  property p_rd_hold; !rvalid |-> $stable(rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_poll_cmd; wr_stb && ph_q == 3'h1 |-> wdata[7:0] == `CMD_BUF_SETUP; endproperty
  a_poll_cmd: assert property (p_poll_cmd) else $error("write before ready");
  property p_setup_poll; s_setup_wr |-> ##[1:8] rd_stb; endproperty
  a_setup_poll: assert property (p_setup_poll) else $error("setup not polled");
  property p_conf_next; wr_stb && ph_q == 3'h4 |-> wdata[7:0] == `CMD_CONFIRM; endproperty
  a_conf_next: assert property (p_conf_next) else $error("confirm missing");
  property p_busy; rvalid && conf_q |-> !rdata[`STAT_READY_BIT]; endproperty
  a_busy: assert property (p_busy) else $error("not busy after confirm");
  property p_done; s_conf_wr |-> ##[1:1000] s_ready_rd; endproperty
  a_done: assert property (p_done) else $error("program never ended");
  property p_botch; rvalid && err_q |-> rdata[`STAT_SEQERR_BIT] && rdata[7]; endproperty
  a_botch: assert property (p_botch) else $error("block change not refused");
endmodule // flash_link_sva

//--- test/tb_flash_buffer_program_cmd_fsm.sv
// bench: host and front end joined on link_a, bench drives a second front end on link_b
// assumes both design ends and flash_cmd_map.svh on the include path
`timescale 1ns/1ns
`include "flash_cmd_map.svh"
module tb_flash_buffer_program_cmd_fsm;
  import flash_cmd_pkg::*;
  // ---
  // wiring
  // ---
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        start_i = 1'b0;
  logic        abort_i = 1'b0;
  logic [23:0] base_addr_i = 24'h000000;
  logic [4:0]  count_m1_i = 5'h00;
  logic [15:0] data_i = 16'h0000;
  logic        take, done_o, busy_o, prog_a, prog_b, erase_b, we_a, we_b;
  logic [7:0]  status_o, sc_b;
  logic [4:0]  wc_a, wc_b, idx_a, n_q;
  logic [15:0] bd_a, q;
  int          error_cnt = 0, cmp_count = 0, wa, pa, pb, eb, wb, i;
  flash_link_if link_a ();
  flash_link_if link_b ();
  always #20 clk_i = ~clk_i;
  flash_buffer_host i_flash_buffer_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_a.host),
    .start_i(start_i), .abort_i(abort_i), .base_addr_i(base_addr_i), .count_m1_i(count_m1_i),
    .data_i(data_i), .data_take_o(take), .done_o(done_o), .busy_o(busy_o), .status_o(status_o));
  flash_command_front_end i_flash_command_front_end (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link(link_a.device), .array_data_i(16'h3c5a), .prog_start_o(prog_a), .erase_start_o(),
    .word_count_o(wc_a), .buf_we_o(we_a), .buf_idx_o(idx_a), .buf_data_o(bd_a), .state_code_o());
  flash_command_front_end i_flash_command_front_end_b (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link(link_b.device), .array_data_i(16'hc3a5), .prog_start_o(prog_b), .erase_start_o(erase_b),
    .word_count_o(wc_b), .buf_we_o(we_b), .buf_idx_o(), .buf_data_o(), .state_code_o(sc_b));
  flash_link_sva i_flash_link_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_stb(link_a.wr_stb),
    .rd_stb(link_a.rd_stb), .addr(link_a.addr), .wdata(link_a.wdata), .rdata(link_a.rdata),
    .rvalid(link_a.rvalid));
  // ---
  // monitors and shared tasks
  // ---
  always @(posedge clk_i) begin
    if (we_a === 1'b1) begin
      chk(16'(idx_a), 16'(n_q - wa[4:0]), "word index");
      chk(bd_a, 16'ha500 + wa[15:0], "word data");
      wa++;
    end
    pa += int'(prog_a === 1'b1);
    pb += int'(prog_b === 1'b1);
    eb += int'(erase_b === 1'b1);
    wb += int'(we_b === 1'b1);
  end
  always @(negedge clk_i) if (take === 1'b1) data_i <= data_i + 16'h0001;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    $display("[FAIL] wait expected end seen timeout");
    conclude();
  endtask
  // idle link lines carry the inverse, never the last value
  task automatic wr2(input logic [23:0] a, input logic [15:0] d);
    @(negedge clk_i);
    link_b.wr_stb = 1'b1;
    link_b.addr = a;
    link_b.wdata = d;
    @(negedge clk_i);
    link_b.wr_stb = 1'b0;
    link_b.addr = ~a;
    link_b.wdata = ~d;
  endtask
  task automatic rd2();
    @(negedge clk_i);
    link_b.rd_stb = 1'b1;
    @(negedge clk_i);
    link_b.rd_stb = 1'b0;
    q = link_b.rdata;
    chk(16'(link_b.rvalid), 16'h0001, "read answer");
  endtask
  task automatic ready2(input logic setup);
    for (i = 0; i < 400; i++) begin
      if (setup) wr2(24'h070000, 16'(`CMD_BUF_SETUP));
      rd2();
      if (q[`STAT_READY_BIT] === 1'b1) break;
    end
    if (i == 400) tmo();
  endtask
  // ---
  // scenarios
  // ---
  task automatic t_buffer(input logic [4:0] n, input int abrt);
    wa = 0;
    pa = 0;
    n_q = n;
    data_i = 16'ha500;
    count_m1_i = n;
    base_addr_i = 24'h050000 + 24'(n);
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    for (i = 0; i < 600; i++) begin
      @(negedge clk_i);
      abort_i = abrt >= 0 && wa >= abrt;
      if (done_o === 1'b1 || (abrt >= 0 && busy_o === 1'b0)) break;
    end
    abort_i = 1'b0;
    if (i == 600) tmo();
    chk(16'(pa), 16'(abrt < 0), "program starts");
    chk(16'(wc_a), 16'(n), "word count");
    if (abrt < 0) begin
      chk(16'(wa), 16'(n) + 16'h0001, "words loaded");
      chk(16'(status_o[7:4]), 16'h0008, "final status");
    end else begin
      chk(16'(status_o[7:4]), 16'h0009, "abort status");
    end
    $display("test buffer program ended");
  endtask
  task automatic t_erase();
    eb = 0;
    wr2(24'h070000, 16'(`CMD_ERASE_SETUP));
    wr2(24'h070000, 16'(`CMD_CONFIRM));
    rd2();
    chk(16'(q[7]), 16'h0000, "erase busy");
    wr2(24'h070000, 16'(`CMD_SUSPEND));
    rd2();
    chk(16'({q[7], q[5]}), 16'h0003, "erase suspended");
    chk(16'(sc_b[3]), 16'h0001, "suspend flag");
    // buffer load while suspended, cut by a block change
    ready2(1'b1);
    wr2(24'h070000, 16'h0001);
    wr2(24'h070000, 16'h0bad);
    wr2(24'h090000, 16'h0bad);
    rd2();
    chk(16'({q[7], q[5], q[4]}), 16'h0007, "suspended block change");
    wr2(24'h070000, 16'(`CMD_CONFIRM));
    rd2();
    chk(16'(q[7]), 16'h0000, "erase resumed");
    ready2(1'b0);
    chk(16'(eb), 16'h0001, "erase starts");
    $display("test erase ended");
  endtask
  task automatic t_seq();
    pb = 0;
    wb = 0;
    ready2(1'b1);
    wr2(24'h070000, 16'hffe2);
    wr2(24'h070000, 16'(`CMD_CONFIRM));
    wr2(24'h070000, 16'(`CMD_BUF_SETUP));
    wr2(24'h070000, 16'h1234);
    chk(16'(wc_b), 16'h0002, "low five count bits");
    wr2(24'h070000, 16'(`CMD_READ_ARRAY));
    rd2();
    chk(16'({q[7], q[4]}), 16'h0003, "confirm refused");
    chk(16'(sc_b[4]), 16'h0001, "error flag");
    chk(16'(wb), 16'h0003, "data words taken");
    wr2(24'h070000, 16'(`CMD_ERASE_SETUP));
    wr2(24'h070000, 16'(`CMD_READ_ARRAY));
    rd2();
    chk(16'({q[7], q[4]}), 16'h0003, "erase confirm refused");
    ready2(1'b1);
    wr2(24'h070000, 16'h0001);
    wr2(24'h070000, 16'h0bad);
    wr2(24'h080000, 16'h0bad);
    rd2();
    chk(16'({q[7], q[4]}), 16'h0003, "block change");
    chk(16'(pb), 16'h0000, "no program start");
    for (int k = 0; k < 2; k++) begin
      wr2(24'h070000, 16'(k ? `CMD_PROG_SETUP_B : `CMD_PROG_SETUP_A));
      wr2(24'h070010, 16'h5aa5);
      rd2();
      chk(16'(q[7]), 16'h0000, "word program busy");
      ready2(1'b0);
    end
    $display("test command errors ended");
  endtask
  task automatic t_reset();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk(16'(wc_b), 16'h0000, "count after reset");
    rd2();
    chk(q, 16'hc3a5, "array after reset");
    $display("test reset ended");
  endtask
  initial begin
    link_b.wr_stb = 1'b0;
    link_b.rd_stb = 1'b0;
    link_b.addr = 24'h000000;
    link_b.wdata = 16'h0000;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    t_buffer(5'h00, -1);
    t_buffer(5'h1f, -1);
    t_buffer(5'h07, 3);
    t_buffer(5'h02, -1);
    t_erase();
    t_seq();
    t_reset();
    conclude();
  end
endmodule // tb_flash_buffer_program_cmd_fsm
